// File: emon_cfg.svh
// Command codes, field positions, reset values and sizes of the energy register bank
`ifndef EMON_CFG_SVH
`define EMON_CFG_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define EMON_CMD_SNAPSHOT 8'hDC
`define EMON_CMD_HYST_LOW 8'hF2
`define EMON_CMD_HYST_HIGH 8'hF3
`define EMON_CMD_HYST_STATUS 8'hF4
`define EMON_CMD_STARTUP_LIM 8'hF6

// ----------------------------------------
// Snapshot fields
// ----------------------------------------
`define EMON_SNAP_COUNT_HI 63
`define EMON_SNAP_COUNT_LO 40
`define EMON_SNAP_WRAP_HI 39
`define EMON_SNAP_WRAP_LO 24
`define EMON_SNAP_ENERGY_HI 23
`define EMON_SNAP_ENERGY_LO 0
`define EMON_ENERGY_MAX 24'h7FFFFF

// ----------------------------------------
// Status and start-up limit fields
// ----------------------------------------
`define EMON_STAT_BELOW_LOW 0
`define EMON_STAT_ABOVE_HIGH 1
`define EMON_STAT_LEVEL 2
`define EMON_STAT_OC_WARN 3
`define EMON_STARTUP_LIM_HI 3
`define EMON_WORD_HI 15
`define EMON_BYTE_HI 7

// ----------------------------------------
// Reset values and answer lengths
// ----------------------------------------
`define EMON_RST_HYST_LOW 16'h0000
`define EMON_RST_HYST_HIGH 16'hFFFF
`define EMON_RST_STARTUP_LIM 4'hF
`define EMON_NBYTES_SNAPSHOT 4'h8
`define EMON_NBYTES_WORD 4'h2
`define EMON_NBYTES_BYTE 4'h1
`define EMON_NBYTES_NONE 4'h0

`endif

// File: emon_pkg.sv
// Types shared by the energy and hysteresis register bank
package emon_pkg;

   typedef struct packed {
      logic write;
      logic [7:0] code;
      logic [15:0] wdata;
   } emon_cmd_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [3:0] nbytes;
      logic [63:0] data;
   } emon_rsp_t;

endpackage

// File: emon_hyst_cmp.sv
// Hysteretic comparator with registered threshold flags and output level
`timescale 1ns/1ns
module emon_hyst_cmp (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [15:0] value_in,
   input wire logic [15:0] low_in,
   input wire logic [15:0] high_in,
   output logic above_out,
   output logic below_out,
   output logic level_out
);

   logic next_above;
   logic next_below;
   logic next_level;

   always_comb begin
      next_above = value_in > high_in;
      next_below = value_in < low_in;
      next_level = level_out;
      // Rising past the upper threshold wins if the thresholds are crossed
      if (next_above) begin
         next_level = 1'b1;
      end else if (next_below) begin
         next_level = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         above_out <= 1'b0;
         below_out <= 1'b0;
         level_out <= 1'b0;
      end else begin
         above_out <= next_above;
         below_out <= next_below;
         level_out <= next_level;
      end
   end

   a_above_flag_track: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      ##1 above_out == ($past(value_in) > $past(high_in)))
      else $error("above flag does not follow upper compare");

   a_below_flag_track: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      ##1 below_out == ($past(value_in) < $past(low_in)))
      else $error("below flag does not follow lower compare");

   a_level_hold_band: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !next_above && !next_below |=> $stable(level_out))
      else $error("level moved inside hysteresis band");

   a_level_goes_high: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      value_in > high_in |=> level_out)
      else $error("level not high above upper threshold");

endmodule

// File: emon_regs.sv
// Energy snapshot, hysteresis thresholds and status, start-up current limit registers
`timescale 1ns/1ns
`include "emon_cfg.svh"

module emon_regs (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire emon_pkg::emon_cmd_t cmd_in,
   input wire logic sample_strobe_in,
   input wire logic [23:0] energy_value_in,
   input wire logic [15:0] compare_value_in,
   input wire logic oc_warn_in,
   output emon_pkg::emon_rsp_t rsp_out,
   output logic hyst_level_out,
   output logic [3:0] startup_limit_out,
   output logic oc_warn_out
);

   // ----------------------------------------
   // Energy counters
   // ----------------------------------------
   logic [23:0] sample_count;
   logic [15:0] energy_wrap_counter;
   logic [23:0] energy_accumulator_value;
   logic [23:0] next_sample_count;
   logic [15:0] next_energy_wrap_counter;
   logic [23:0] next_energy_accumulator_value;
   logic energy_wrapped;

   // A drop in the accumulator between two samples can only be a wrap
   // past the top of its range, since it never counts down.
   assign energy_wrapped = sample_strobe_in
      && ((energy_value_in & `EMON_ENERGY_MAX) < energy_accumulator_value);

   always_comb begin
      next_sample_count = sample_count;
      next_energy_wrap_counter = energy_wrap_counter;
      next_energy_accumulator_value = energy_accumulator_value;
      if (sample_strobe_in) begin
         next_sample_count = sample_count + 24'h000001;
         next_energy_accumulator_value = energy_value_in & `EMON_ENERGY_MAX;
      end
      if (energy_wrapped) begin
         next_energy_wrap_counter = energy_wrap_counter + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sample_count <= 24'h000000;
         energy_wrap_counter <= 16'h0000;
         energy_accumulator_value <= 24'h000000;
      end else begin
         sample_count <= next_sample_count;
         energy_wrap_counter <= next_energy_wrap_counter;
         energy_accumulator_value <= next_energy_accumulator_value;
      end
   end

   // ----------------------------------------
   // Hysteresis comparison
   // ----------------------------------------
   logic [15:0] hyst_low;
   logic [15:0] hyst_high;
   logic above_upper_threshold_flag;
   logic below_lower_threshold_flag;
   logic hysteretic_output_level;

   emon_hyst_cmp u_hyst_cmp (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .value_in(compare_value_in),
      .low_in(hyst_low),
      .high_in(hyst_high),
      .above_out(above_upper_threshold_flag),
      .below_out(below_lower_threshold_flag),
      .level_out(hysteretic_output_level)
   );

   // Comes straight from the comparator flop, ready for GPO routing
   assign hyst_level_out = hysteretic_output_level;

   // ----------------------------------------
   // Writable registers and the registered overcurrent warning flag
   // ----------------------------------------
   logic [3:0] startup_current_limit_field;
   logic output_overcurrent_warning_flag;
   logic [15:0] next_hyst_low;
   logic [15:0] next_hyst_high;
   logic [3:0] next_startup_limit;
   logic wr_req;

   assign wr_req = cmd_valid_in && cmd_in.write;

   always_comb begin
      next_hyst_low = hyst_low;
      next_hyst_high = hyst_high;
      next_startup_limit = startup_current_limit_field;
      if (wr_req) begin
         case (cmd_in.code)
            `EMON_CMD_HYST_LOW: begin
               next_hyst_low = cmd_in.wdata;
            end
            `EMON_CMD_HYST_HIGH: begin
               next_hyst_high = cmd_in.wdata;
            end
            `EMON_CMD_STARTUP_LIM: begin
               // Upper bits are dropped: they do not exist
               next_startup_limit = cmd_in.wdata[`EMON_STARTUP_LIM_HI:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         hyst_low <= `EMON_RST_HYST_LOW;
         hyst_high <= `EMON_RST_HYST_HIGH;
         startup_current_limit_field <= `EMON_RST_STARTUP_LIM;
         output_overcurrent_warning_flag <= 1'b0;
      end else begin
         hyst_low <= next_hyst_low;
         hyst_high <= next_hyst_high;
         startup_current_limit_field <= next_startup_limit;
         output_overcurrent_warning_flag <= oc_warn_in;
      end
   end

   assign startup_limit_out = startup_current_limit_field;
   assign oc_warn_out = output_overcurrent_warning_flag;

   // ----------------------------------------
   // Read answers
   // ----------------------------------------
   emon_pkg::emon_rsp_t next_rsp;
   logic [7:0] status_byte;

   always_comb begin
      status_byte = 8'h00;
      status_byte[`EMON_STAT_BELOW_LOW] = below_lower_threshold_flag;
      status_byte[`EMON_STAT_ABOVE_HIGH] = above_upper_threshold_flag;
      status_byte[`EMON_STAT_LEVEL] = hysteretic_output_level;
      status_byte[`EMON_STAT_OC_WARN] = output_overcurrent_warning_flag;
   end

   always_comb begin
      next_rsp = '0;
      next_rsp.valid = cmd_valid_in;
      if (cmd_valid_in) begin
         case (cmd_in.code)
            `EMON_CMD_SNAPSHOT: begin
               // Every field is taken from the same cycle, so a sample landing
               // mid-transfer cannot tear the word apart.
               next_rsp.err = cmd_in.write;
               next_rsp.nbytes = `EMON_NBYTES_SNAPSHOT;
               next_rsp.data[`EMON_SNAP_COUNT_HI:`EMON_SNAP_COUNT_LO] = sample_count;
               next_rsp.data[`EMON_SNAP_WRAP_HI:`EMON_SNAP_WRAP_LO] = energy_wrap_counter;
               next_rsp.data[`EMON_SNAP_ENERGY_HI:`EMON_SNAP_ENERGY_LO] =
                  energy_accumulator_value;
            end
            `EMON_CMD_HYST_LOW: begin
               next_rsp.nbytes = `EMON_NBYTES_WORD;
               next_rsp.data[`EMON_WORD_HI:0] = hyst_low;
            end
            `EMON_CMD_HYST_HIGH: begin
               next_rsp.nbytes = `EMON_NBYTES_WORD;
               next_rsp.data[`EMON_WORD_HI:0] = hyst_high;
            end
            `EMON_CMD_HYST_STATUS: begin
               next_rsp.err = cmd_in.write;
               next_rsp.nbytes = `EMON_NBYTES_BYTE;
               next_rsp.data[`EMON_BYTE_HI:0] = status_byte;
            end
            `EMON_CMD_STARTUP_LIM: begin
               next_rsp.nbytes = `EMON_NBYTES_WORD;
               next_rsp.data[`EMON_STARTUP_LIM_HI:0] = startup_current_limit_field;
            end
            default: begin
               next_rsp.err = 1'b1;
            end
         endcase
         // A write returns only its acknowledge, never data
         if (cmd_in.write) begin
            next_rsp.data = '0;
            next_rsp.nbytes = `EMON_NBYTES_NONE;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rsp_out <= '0;
      end else begin
         rsp_out <= next_rsp;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_snap_read;
      cmd_valid_in && !cmd_in.write && cmd_in.code == `EMON_CMD_SNAPSHOT;
   endsequence

   sequence s_sample_then_idle;
      sample_strobe_in ##1 !sample_strobe_in;
   endsequence

   a_snap_atomic: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_snap_read |=> rsp_out.valid && rsp_out.nbytes == `EMON_NBYTES_SNAPSHOT
         && rsp_out.data[`EMON_SNAP_COUNT_HI:`EMON_SNAP_COUNT_LO] == $past(sample_count)
         && rsp_out.data[`EMON_SNAP_WRAP_HI:`EMON_SNAP_WRAP_LO] == $past(energy_wrap_counter)
         && rsp_out.data[`EMON_SNAP_ENERGY_HI:`EMON_SNAP_ENERGY_LO]
            == $past(energy_accumulator_value))
      else $error("snapshot fields not from one cycle");

   a_sample_count_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_sample_then_idle |-> sample_count == $past(sample_count) + 24'h000001)
      else $error("sample count did not step by one");

   a_wrap_count_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sample_strobe_in && energy_accumulator_value == `EMON_ENERGY_MAX
         && energy_value_in == 24'h000000
         |=> energy_wrap_counter == $past(energy_wrap_counter) + 16'h0001)
      else $error("wrap counter missed a rollover");

   a_wrap_count_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !sample_strobe_in |=> $stable(energy_wrap_counter))
      else $error("wrap counter moved without a sample");

   a_low_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_req && cmd_in.code == `EMON_CMD_HYST_LOW |=> hyst_low == $past(cmd_in.wdata))
      else $error("lower threshold write lost");

   a_high_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_req && cmd_in.code == `EMON_CMD_HYST_HIGH |=> hyst_high == $past(cmd_in.wdata))
      else $error("upper threshold write lost");

   a_status_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      cmd_valid_in && !cmd_in.write && cmd_in.code == `EMON_CMD_HYST_STATUS
         |=> rsp_out.data[7:4] == 4'h0 && rsp_out.data[2] == $past(hysteretic_output_level)
         && rsp_out.data[3] == $past(output_overcurrent_warning_flag))
      else $error("status byte wrong");

   a_oc_warn_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      oc_warn_in ##1 oc_warn_in |-> output_overcurrent_warning_flag)
      else $error("overcurrent warning not reported");

   a_startup_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      cmd_valid_in && !cmd_in.write && cmd_in.code == `EMON_CMD_STARTUP_LIM
         |=> rsp_out.data[15:4] == 12'h000
         && rsp_out.data[3:0] == $past(startup_current_limit_field))
      else $error("start-up limit read wrong");

   a_level_pin: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      hyst_level_out == hysteretic_output_level && $rose(hyst_level_out)
         |-> $past(above_upper_threshold_flag) || above_upper_threshold_flag)
      else $error("level pin rose without upper crossing");

   a_status_flags: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      cmd_valid_in && !cmd_in.write && cmd_in.code == `EMON_CMD_HYST_STATUS
         |=> rsp_out.data[`EMON_STAT_ABOVE_HIGH] == $past(above_upper_threshold_flag)
         && rsp_out.data[`EMON_STAT_BELOW_LOW] == $past(below_lower_threshold_flag))
      else $error("status threshold flags wrong");

   a_snap_bytes: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_snap_read |=> rsp_out.data[63:56] == $past(sample_count[23:16])
         && rsp_out.data[31:24] == $past(energy_wrap_counter[7:0])
         && rsp_out.data[23:16] == $past(energy_accumulator_value[23:16]))
      else $error("snapshot bytes out of order");

   a_startup_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_req && cmd_in.code == `EMON_CMD_STARTUP_LIM
         |=> startup_current_limit_field == $past(cmd_in.wdata[`EMON_STARTUP_LIM_HI:0]))
      else $error("start-up limit write lost");

   // Deliberately not disabled by reset: this one watches the reset itself
   a_reset_values: assert property (@(posedge clk_sys_in)
      !rst_n_in |=> hyst_low == `EMON_RST_HYST_LOW && hyst_high == `EMON_RST_HYST_HIGH
         && startup_current_limit_field == `EMON_RST_STARTUP_LIM)
      else $error("register not at reset value");

   a_oc_warn_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !oc_warn_in |=> !output_overcurrent_warning_flag)
      else $error("overcurrent warning stuck");

endmodule

// File: emon_host.sv
// Management-bus host model that issues one command and collects its answer
`timescale 1ns/1ns
module emon_host (
   input wire logic clk_sys_in,
   input wire emon_pkg::emon_rsp_t rsp_in,
   output logic cmd_valid_out,
   output emon_pkg::emon_cmd_t cmd_out
);
   // ----------------------------------------
   // Command transfer
   // ----------------------------------------
   initial begin
      cmd_valid_out = 1'b0;
      cmd_out = '0;
   end

   // Entered at a falling edge, returns at the falling edge after the answer cycle
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
         output emon_pkg::emon_rsp_t rsp);
      cmd_valid_out = 1'b1;
      cmd_out = {wr, code, wdata};
      @(negedge clk_sys_in);
      rsp = rsp_in;
      cmd_valid_out = 1'b0;
      // Idle command word inverted so a stale word never looks like a fresh one
      cmd_out = ~cmd_out;
      @(negedge clk_sys_in);
   endtask
endmodule

// File: testbench.sv
// Self-checking bench for the energy and hysteresis register bank
`timescale 1ns/1ns
`include "emon_cfg.svh"
module testbench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic [7:0] code;
      logic [15:0] wdata;
      logic err;
      logic [3:0] nbytes;
      logic [63:0] data;
   } emon_row_t;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic cmd_valid;
   emon_pkg::emon_cmd_t cmd;
   logic sample_strobe = 1'b0;
   logic [23:0] energy_value = 24'h000000;
   logic [15:0] compare_value = 16'h0000;
   logic oc_warn = 1'b0;
   emon_pkg::emon_rsp_t rsp;
   emon_pkg::emon_rsp_t r;
   logic hyst_level;
   logic [3:0] startup_limit;
   logic oc_warn_q;
   int bad_count = 0;
   int check_count = 0;
   logic [15:0] hv [6] = '{16'h3000, 16'h1800, 16'h2000, 16'h0800, 16'h1800, 16'h1000};
   logic [7:0] hs [6] = '{8'h06, 8'h04, 8'h04, 8'h01, 8'h08, 8'h00};
   // First five rows are reset values, reused after the mid-run reset
   emon_row_t rows [15] = '{
      {1'b0, `EMON_CMD_HYST_LOW, 16'h0000, 1'b0, 4'h2, 64'h0},
      {1'b0, `EMON_CMD_HYST_HIGH, 16'h0000, 1'b0, 4'h2, 64'hFFFF},
      {1'b0, `EMON_CMD_STARTUP_LIM, 16'h0000, 1'b0, 4'h2, 64'hF},
      {1'b0, `EMON_CMD_HYST_STATUS, 16'h0000, 1'b0, 4'h1, 64'h0},
      {1'b0, `EMON_CMD_SNAPSHOT, 16'h0000, 1'b0, 4'h8, 64'h0},
      {1'b1, `EMON_CMD_HYST_LOW, 16'h1234, 1'b0, 4'h0, 64'h0},
      {1'b0, `EMON_CMD_HYST_LOW, 16'h0000, 1'b0, 4'h2, 64'h1234},
      {1'b1, `EMON_CMD_HYST_HIGH, 16'hABCD, 1'b0, 4'h0, 64'h0},
      {1'b0, `EMON_CMD_HYST_HIGH, 16'h0000, 1'b0, 4'h2, 64'hABCD},
      {1'b1, `EMON_CMD_STARTUP_LIM, 16'h1235, 1'b0, 4'h0, 64'h0},
      {1'b0, `EMON_CMD_STARTUP_LIM, 16'h0000, 1'b0, 4'h2, 64'h5},
      {1'b1, `EMON_CMD_SNAPSHOT, 16'hFFFF, 1'b1, 4'h0, 64'h0},
      {1'b1, `EMON_CMD_HYST_STATUS, 16'h00FF, 1'b1, 4'h0, 64'h0},
      {1'b0, 8'h00, 16'h0000, 1'b1, 4'h0, 64'h0},
      {1'b0, `EMON_CMD_HYST_LOW, 16'h0000, 1'b0, 4'h2, 64'h1234}};

   always #5 clk_sys_in = ~clk_sys_in;

   emon_host host (
      .clk_sys_in(clk_sys_in),
      .rsp_in(rsp),
      .cmd_valid_out(cmd_valid),
      .cmd_out(cmd)
   );

   emon_regs uut (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .cmd_valid_in(cmd_valid),
      .cmd_in(cmd),
      .sample_strobe_in(sample_strobe),
      .energy_value_in(energy_value),
      .compare_value_in(compare_value),
      .oc_warn_in(oc_warn),
      .rsp_out(rsp),
      .hyst_level_out(hyst_level),
      .startup_limit_out(startup_limit),
      .oc_warn_out(oc_warn_q)
   );

   // ----------------------------------------
   // Checking and verdict
   // ----------------------------------------
   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic run_rows(input int first, input int last);
      for (int i = first; i <= last; i++) begin
         host.xfer(rows[i].wr, rows[i].code, rows[i].wdata, r);
         check(r, {1'b1, rows[i].err, rows[i].nbytes, rows[i].data});
      end
   endtask

   initial begin
      #20000;
      bad_count++;
      results();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (8) @(negedge clk_sys_in);
      check({rsp, hyst_level, startup_limit, oc_warn_q}, {70'h0, 1'b0, 4'hF, 1'b0});
      rst_n_in = 1'b1;
      @(negedge clk_sys_in);
      run_rows(0, 14);
      check(startup_limit, 4'h5);
      // Wrap from the top value, then a read taken at the same edge as a sample
      sample_strobe = 1'b1;
      energy_value = `EMON_ENERGY_MAX;
      @(negedge clk_sys_in);
      energy_value = 24'h000000;
      @(negedge clk_sys_in);
      energy_value = 24'h000123;
      fork
         host.xfer(1'b0, `EMON_CMD_SNAPSHOT, 16'h0000, r);
         begin
            @(negedge clk_sys_in);
            sample_strobe = 1'b0;
         end
      join
      check(r, {1'b1, 1'b0, 4'h8, 24'h000002, 16'h0001, 24'h000000});
      host.xfer(1'b0, `EMON_CMD_SNAPSHOT, 16'h0000, r);
      check(r, {1'b1, 1'b0, 4'h8, 24'h000003, 16'h0001, 24'h000123});
      // Hysteresis band 0x1000..0x2000, strict comparisons
      host.xfer(1'b1, `EMON_CMD_HYST_LOW, 16'h1000, r);
      host.xfer(1'b1, `EMON_CMD_HYST_HIGH, 16'h2000, r);
      for (int i = 0; i < 6; i++) begin
         compare_value = hv[i];
         oc_warn = hs[i][3];
         @(negedge clk_sys_in);
         host.xfer(1'b0, `EMON_CMD_HYST_STATUS, 16'h0000, r);
         check({r, hyst_level, oc_warn_q}, {1'b1, 5'h01, 56'h0, hs[i], hs[i][2], hs[i][3]});
      end
      // Mid-run reset restores every register to its reset value
      rst_n_in = 1'b0;
      compare_value = 16'h0000;
      oc_warn = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      @(negedge clk_sys_in);
      check({rsp, hyst_level, startup_limit, oc_warn_q}, {70'h0, 1'b0, 4'hF, 1'b0});
      run_rows(0, 4);
      results();
   end
endmodule
